// ===== rtl/fuse_prog_pkg.sv
// package for the fuse prom host controller: geometry, timing, types
// assumes a 100 mhz clock; all counts derived from times in ns
package fuse_prog_pkg;
    localparam int unsigned ADDR_W       = 5;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned WORDS        = 32;
    localparam int unsigned CLK_NS       = 10;
    // pulse width 1 us..40 us; we use 10 us
    localparam int unsigned PULSE_NS     = 10000;
    localparam int unsigned PULSE_CYC    = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    // period at least 4x width keeps duty at 25 percent
    localparam int unsigned DUTY_PCT     = 25;
    localparam int unsigned PERIOD_CYC   = PULSE_CYC * 100 / DUTY_PCT;
    // address and inhibit settle time before a read is sampled (55 ns)
    localparam int unsigned ACCESS_NS    = 55;
    localparam int unsigned ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned MAX_PULSES   = 9;
    localparam int unsigned PULSES_PER_LEVEL = 3;
    localparam int unsigned CNT_W        = 16;
    localparam logic [3:0]  PULSE_CNT_RST = 4'h0;
    // programming level select (20 v, 23 v, 26 v)
    typedef enum logic [1:0] {
        LEVEL_20V = 2'h0,
        LEVEL_23V = 2'h1,
        LEVEL_26V = 2'h2
    } level_t;
    // pin drive bundle toward the prom
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              inhibit;
        logic [DATA_W-1:0] pulse_oh;
        level_t            level;
    } pins_t;
    // command from user side
    typedef struct packed {
        logic              prog;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;
endpackage

// ===== rtl/fuse_sync.sv
// two flop synchroniser for the prom output pins
// assumes the data pins are asynchronous to i_clk
module fuse_sync #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;
    // a zero-width synchroniser has nothing to carry
    if (WIDTH < 1) begin : g_width_check
        $error("fuse_sync needs a width of at least one");
    end
    // unprogrammed pins idle high, so reset to all ones
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= '1;
            sync_reg <= '1;
        end else if (i_ce) begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end
    assign o_sync = sync_reg;
endmodule

// ===== rtl/fuse_prog_host.sv
// host controller that reads and programs a 32x8 fuse prom
// assumes prom data pins are open collector and sampled through sync
// Functional notes
// - address held steady while programming pulses are applied
// - only one output bit pulsed at any moment
// - inhibit kept high throughout every programming pulse
// - verify by driving inhibit low and reading the bit low
// - verify after each pulse; advance once programmed or after nine pulses, else pulse again
// - level 20 v pulses 1-3, 23 v 4-6, 26 v 7-9
// - pulse width to period ratio kept at or below 25 percent
module fuse_prog_host
    import fuse_prog_pkg::*;
(
    input  wire logic                        i_clk,
    input  wire logic                        i_reset,
    input  wire logic                        i_ce,
    input  wire fuse_prog_pkg::cmd_t         i_cmd,
    input  wire logic                        i_cmd_valid,
    input  wire logic [fuse_prog_pkg::DATA_W-1:0] i_q,
    output fuse_prog_pkg::pins_t             o_pins,
    output logic                             o_pulse_en,
    output logic                             o_busy,
    output logic                             o_done,
    output logic [fuse_prog_pkg::DATA_W-1:0] o_rdata,
    output logic                             o_fail
);
    import fuse_prog_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE, S_READ, S_SCAN, S_PULSE, S_REST, S_VERIFY, S_FINISH
    } state_t;

    logic [DATA_W-1:0] q_sync;
    state_t            state_reg, state_next;
    pins_t             pins_reg, pins_next;
    logic              pen_reg, pen_next;
    logic [DATA_W-1:0] todo_reg, todo_next;
    logic [2:0]        bit_reg, bit_next;
    logic [3:0]        npulse_reg, npulse_next;
    logic [CNT_W-1:0]  cnt_reg, cnt_next;
    logic              busy_reg, busy_next;
    logic              done_reg, done_next;
    logic              fail_reg, fail_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [DATA_W-1:0] onehot;

    // prom pins come from another domain
    fuse_sync #(.WIDTH(DATA_W)) u_sync (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_ce   (i_ce),
        .i_async(i_q),
        .o_sync (q_sync)
    );

    // one-hot select of the bit in work; never more than one set
    assign onehot = DATA_W'(1) << bit_reg;

    // level from pulse count, counted from zero
    function automatic level_t level_of(input logic [3:0] n);
        if (n < 4'(PULSES_PER_LEVEL))
            return LEVEL_20V;
        else if (n < 4'(2 * PULSES_PER_LEVEL))
            return LEVEL_23V;
        return LEVEL_26V;
    endfunction

    // sequencer next state
    always_comb begin
        state_next  = state_reg;
        pins_next   = pins_reg;
        pen_next    = 1'b0;
        todo_next   = todo_reg;
        bit_next    = bit_reg;
        npulse_next = npulse_reg;
        cnt_next    = cnt_reg;
        busy_next   = busy_reg;
        done_next   = 1'b0;
        fail_next   = fail_reg;
        rdata_next  = rdata_reg;
        case (state_reg)
            S_IDLE: begin
                pins_next.inhibit  = 1'b1;
                pins_next.pulse_oh = '0;
                if (i_cmd_valid) begin
                    pins_next.addr = i_cmd.addr;
                    busy_next      = 1'b1;
                    fail_next      = 1'b0;
                    cnt_next       = '0;
                    // only zero bits need a fuse blown
                    todo_next      = ~i_cmd.data;
                    bit_next       = '0;
                    if (i_cmd.prog) begin
                        state_next = S_SCAN;
                    end else begin
                        pins_next.inhibit = 1'b0;
                        state_next        = S_READ;
                    end
                end
            end
            S_READ: begin
                // wait access time plus sync delay, then sample
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(ACCESS_CYC + 2)) begin
                    rdata_next = q_sync;
                    state_next = S_FINISH;
                end
            end
            S_SCAN: begin
                npulse_next = PULSE_CNT_RST;
                cnt_next    = '0;
                if (todo_reg[bit_reg]) begin
                    pins_next.inhibit = 1'b1;
                    state_next        = S_PULSE;
                end else if (bit_reg == 3'(DATA_W - 1)) begin
                    state_next = S_FINISH;
                end else begin
                    bit_next = bit_reg + 1'b1;
                end
            end
            S_PULSE: begin
                // address and inhibit held, single bit raised
                pins_next.level    = level_of(npulse_reg);
                pins_next.pulse_oh = onehot;
                pen_next           = 1'b1;
                cnt_next           = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(PULSE_CYC - 1)) begin
                    pins_next.pulse_oh = '0;
                    pen_next           = 1'b0;
                    npulse_next        = npulse_reg + 1'b1;
                    state_next         = S_REST;
                end
            end
            S_REST: begin
                // off time starts here and S_VERIFY completes the period, duty stays at quarter
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == CNT_W'(PULSE_CYC + 1)) begin
                    pins_next.inhibit = 1'b0;
                end
                if (cnt_reg == CNT_W'(PULSE_CYC + ACCESS_CYC + 4)) begin
                    state_next = S_VERIFY;
                end
            end
            S_VERIFY: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(PERIOD_CYC - 1)) begin
                    pins_next.inhibit = 1'b1;
                    cnt_next          = '0;
                    if (!q_sync[bit_reg] ||
                        npulse_reg == 4'(MAX_PULSES)) begin
                        if (q_sync[bit_reg])
                            fail_next = 1'b1;
                        todo_next[bit_reg] = 1'b0;
                        state_next         = S_SCAN;
                    end else begin
                        state_next = S_PULSE;
                    end
                end
            end
            S_FINISH: begin
                pins_next.inhibit = 1'b1;
                busy_next         = 1'b0;
                done_next         = 1'b1;
                state_next        = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
    end

    // registers, frozen while clock enable is low
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_reg  <= S_IDLE;
            pins_reg   <= '{addr: '0, inhibit: 1'b1, pulse_oh: '0,
                            level: LEVEL_20V};
            pen_reg    <= 1'b0;
            todo_reg   <= '0;
            bit_reg    <= '0;
            npulse_reg <= PULSE_CNT_RST;
            cnt_reg    <= '0;
            busy_reg   <= 1'b0;
            done_reg   <= 1'b0;
            fail_reg   <= 1'b0;
            rdata_reg  <= '1;
        end else if (i_ce) begin
            state_reg  <= state_next;
            pins_reg   <= pins_next;
            pen_reg    <= pen_next;
            todo_reg   <= todo_next;
            bit_reg    <= bit_next;
            npulse_reg <= npulse_next;
            cnt_reg    <= cnt_next;
            busy_reg   <= busy_next;
            done_reg   <= done_next;
            fail_reg   <= fail_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign o_pins     = pins_reg;
    assign o_pulse_en = pen_reg;
    assign o_busy     = busy_reg;
    assign o_done     = done_reg;
    assign o_fail     = fail_reg;
    assign o_rdata    = rdata_reg;

    // checks
    one_bit_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        $onehot0(pins_reg.pulse_oh))
        else $error("more than one output pulsed");
    inhibit_pulse_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (pins_reg.pulse_oh != '0) |-> pins_reg.inhibit)
        else $error("pulse with inhibit low");
    addr_hold_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (pins_reg.pulse_oh != '0) && $past(pins_reg.pulse_oh != '0)
        |-> $stable(pins_reg.addr))
        else $error("address moved during pulse");
    pulse_level_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        pen_reg |-> pins_reg.level == (npulse_reg < 4'h3 ? LEVEL_20V :
                                       npulse_reg < 4'h6 ? LEVEL_23V :
                                       LEVEL_26V))
        else $error("wrong level for pulse count");
    verify_enable_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        state_reg == S_VERIFY |-> !pins_reg.inhibit)
        else $error("verify with inhibit high");
    pulse_cap_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        npulse_reg <= 4'(MAX_PULSES))
        else $error("more than nine pulses");
    duty_cycle_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_ce && $fell(pen_reg) |-> !pen_reg [*8])
        else $error("pulse too soon after previous");
    read_enable_a: assert property (
        @(posedge i_clk) disable iff (i_reset)
        state_reg == S_READ |-> !pins_reg.inhibit)
        else $error("read with inhibit high");
    cov_read_c: cover property (@(posedge i_clk) state_reg == S_READ
        ##1 state_reg == S_FINISH);
    cov_prog_c: cover property (@(posedge i_clk) $rose(pen_reg));
    cov_fail_c: cover property (@(posedge i_clk) $rose(fail_reg));
endmodule

// ===== test/fuse_prom_model.sv
// behavioural 32x8 fuse prom facing the host controller
// assumes pins driven by fuse_prog_host; misuse is counted in o_viol
module fuse_prom_model (
    input  wire fuse_prog_pkg::pins_t i_pins,
    input  wire logic                 i_pulse_en,
    input  wire logic [3:0]           i_need,
    output logic [7:0]                o_q,
    output int                        o_viol
);
    timeunit 1ns;
    timeprecision 1ps;
    import fuse_prog_pkg::*;
    logic [7:0] mem [32];
    int         cnt [32][8];
    int         bit_i;
    logic [4:0] addr_r;
    logic       on;
    realtime    rise_t, width_t, per;
    // blank part: every fuse intact
    initial begin
        foreach (mem[a]) mem[a] = 8'hff;
        on = 1'b0;
    end
    // open collector outputs float high while inhibited
    assign o_q = i_pins.inhibit ? 8'hff
                                : mem[i_pins.addr];
    // pulse start: one bit, inhibited, level from count, duty
    always begin
        @(posedge i_pulse_en);
        per = $realtime - rise_t;
        rise_t = $realtime;
        #1;
        on = 1'b1;
        addr_r = i_pins.addr;
        for (int b = 0; b < 8; b++)
            if (i_pins.pulse_oh[b]) bit_i = b;
        cnt[addr_r][bit_i]++;
        if ($countones(i_pins.pulse_oh) != 1) o_viol++;
        if (!i_pins.inhibit) o_viol++;
        if (cnt[addr_r][bit_i] > MAX_PULSES) o_viol++;
        else if (int'(i_pins.level) != (cnt[addr_r][bit_i] - 1) / 3)
            o_viol++;
        if (width_t > 0 && width_t * 4 > per) o_viol++;
    end
    // pulse end: fuse opens once it has had enough pulses
    always begin
        @(negedge i_pulse_en);
        on = 1'b0;
        width_t = $realtime - rise_t;
        if (cnt[addr_r][bit_i] >= i_need) mem[addr_r][bit_i] = 1'b0;
    end
    // address steady and inhibit high for the whole pulse
    always @(i_pins)
        if (on && (i_pins.addr != addr_r || !i_pins.inhibit))
            o_viol++;
endmodule

// ===== test/fuse_prog_host_bench.sv
// self-checking bench for the fuse prom host controller
// assumes a 100 mhz clock and the behavioural prom model beside it
module fuse_prog_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import fuse_prog_pkg::*;
    logic       i_clk, i_reset, i_ce, i_cmd_valid;
    cmd_t       i_cmd;
    pins_t      o_pins;
    logic       o_pulse_en, o_busy, o_done, o_fail;
    logic [7:0] o_rdata, q;
    logic [3:0] need;
    int         viol, error_cnt, checks_done, seed;
    logic [7:0] ref_mem [32];
    fuse_prog_host dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid), .i_q(q),
        .o_pins(o_pins), .o_pulse_en(o_pulse_en), .o_busy(o_busy),
        .o_done(o_done), .o_rdata(o_rdata), .o_fail(o_fail));
    fuse_prom_model prom (.i_pins(o_pins), .i_pulse_en(o_pulse_en),
        .i_need(need), .o_q(q), .o_viol(viol));
    // 100 mhz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // compare and count
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask
    // verdict and end of run
    task automatic results();
        if (error_cnt == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one command, bounded wait for done; ce jitters on reads
    task automatic op(input logic p, input logic [4:0] a,
                      input logic [7:0] d);
        int n;
        @(negedge i_clk);
        i_cmd = '{p, a, d};
        i_cmd_valid = 1'b1;
        @(negedge i_clk);
        i_cmd_valid = 1'b0;
        chk("busy", 8'h01, {7'h0, o_busy});
        n = 0;
        while (o_done !== 1'b1 && n < 50000) begin
            @(negedge i_clk);
            i_ce = p | ($random(seed) % 4 != 0);
            n++;
        end
        i_ce = 1'b1;
        if (n == 50000) begin
            error_cnt++;
            results();
        end
        chk("busy end", 8'h00, {7'h0, o_busy});
    endtask
    // read a word and compare with the bench copy
    task automatic rd(input int ai);
        int r;
        r = $random(seed);
        op(1'b0, ai[4:0], r[7:0]);
        chk("rdata", ref_mem[ai[4:0]], o_rdata);
        chk("fail", 8'h00, {7'h0, o_fail});
    endtask
    // program a word, prom needs n pulses per bit, then read back
    task automatic pg(input int ai, input logic [7:0] d, input int n);
        need = n[3:0];
        op(1'b1, ai[4:0], d);
        chk("fail", {7'h0, n > 9}, {7'h0, o_fail});
        if (n <= 9) ref_mem[ai[4:0]] &= d;
        rd(ai);
    endtask
    // main sequence
    initial begin
        seed = 32'h89b3;
        i_reset = 1'b1;
        i_ce = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd = '0;
        need = 4'h1;
        error_cnt = 0;
        checks_done = 0;
        foreach (ref_mem[k]) ref_mem[k] = 8'hff;
        repeat (5) @(negedge i_clk);
        i_reset = 1'b0;
        chk("inhibit", 8'h01, {7'h0, o_pins.inhibit});
        chk("idle rdata", 8'hff, o_rdata);
        repeat (4) rd($random(seed));
        pg(5, 8'hfe, 1);
        pg(16 + ($random(seed) & 15), 8'h7f, 4);
        pg(3, 8'hbf, 10);
        rd(5);
        chk("misuse", 8'h00, {7'h0, viol != 0});
        results();
    end
endmodule
